/* core/dphp_pkg.sv */
package dphp_pkg;

   // ************************************************
   // register indices, shared by host and internal cpu
   // ************************************************
   localparam logic [2:0] ADDR_WR_HIGH = 3'h0;
   localparam logic [2:0] ADDR_WR_LOW = 3'h1;
   localparam logic [2:0] ADDR_RD_HIGH = 3'h2;
   localparam logic [2:0] ADDR_RD_LOW = 3'h3;
   localparam logic [2:0] ADDR_QUERY = 3'h4;
   localparam logic [2:0] ADDR_CSR = 3'h5;

   // ************************************************
   // port_control_status fields
   // ************************************************
   localparam int BIT_QUERY = 7;
   localparam int BIT_WRQ_EN = 6;
   localparam int BIT_RDY_WR_EN = 5;
   localparam int BIT_RDY_RD_EN = 4;
   localparam int BIT_WR_END = 3;
   localparam int BIT_RD_END = 2;
   localparam int BIT_WR_IRQ_EN = 1;
   localparam int BIT_RD_IRQ_EN = 0;
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // ************************************************
   // timing and pin reset levels
   // ************************************************
   localparam int CLOCK_HZ = 20_000_000;
   localparam logic [3:0] WAIT_CLOCKS = 4'h8;
   localparam logic [2:0] STROBE_IDLE = 3'h7;
   localparam logic [10:0] BUS_IDLE = 11'h000;

   typedef enum logic [1:0] {DPHP_BOUND, DPHP_DIRECT, DPHP_HANDSHAKE} dphp_mode_t;

   typedef struct packed {
      logic sel;
      logic wr;
      logic rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } dphp_cpu_req_t;

   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic [7:0] data;
   } dphp_ram_req_t;

   function automatic dphp_mode_t dphp_mode(input logic hs, input logic dw);
      dphp_mode_t m;
      m = hs ? DPHP_HANDSHAKE : (dw ? DPHP_DIRECT : DPHP_BOUND);
      return m;
   endfunction

endpackage

/* core/dphp_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module dphp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] IDLE = '0
) (
   // system
   input wire logic clock,
   input wire logic reset_n,
   // pins
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         stage <= IDLE;
         sync_out <= IDLE;
      end else begin
         stage <= pin_in;
         sync_out <= stage;
      end
   end
endmodule

`default_nettype wire

/* core/dphp_wait_timer.sv */
`timescale 1ns/100ps
`default_nettype none

module dphp_wait_timer (
   // system
   input wire logic clock,
   input wire logic reset_n,
   // control
   input wire logic arm,
   output logic done
);
   import dphp_pkg::*;

   typedef enum logic {T_IDLE, T_COUNT} dphp_tstate_t;
   dphp_tstate_t state;
   logic [3:0] count;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state <= T_IDLE;
         count <= 4'h0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         unique case (state)
            T_IDLE: begin
               count <= 4'h1;
               if (arm) begin
                  state <= T_COUNT;
               end
            end
            T_COUNT: begin
               count <= count + 4'h1;
               if (!arm) begin
                  state <= T_IDLE;
               end else if (count == WAIT_CLOCKS - 4'h1) begin
                  done <= 1'b1;
                  state <= T_IDLE;
               end
            end
         endcase
      end
   end
endmodule

`default_nettype wire

/* core/dphp_port.sv */
`timescale 1ns/100ps
`default_nettype none

module dphp_port (
   // system
   input wire logic clock,
   input wire logic reset_n,
   // mode selection
   input wire logic dual_port_enable,
   input wire logic handshake_enable,
   input wire logic direct_word_select,
   // host pins
   input wire logic host_cs_n,
   input wire logic host_we_n,
   input wire logic host_oe_n,
   input wire logic [2:0] host_addr,
   input wire logic [7:0] host_data_bus_in,
   output logic [7:0] host_data_bus_out,
   output logic host_data_bus_oe_n,
   output logic ready_out,
   output logic ready_oe_n,
   output logic wait_request_n_out,
   output logic wait_request_n_oe_n,
   // general port behind the wait-request pin
   input wire logic port_level,
   input wire logic port_oe_n,
   // internal cpu
   input wire dphp_pkg::dphp_cpu_req_t cpu_req,
   output logic [7:0] cpu_rdata,
   output logic write_end_irq,
   output logic read_end_irq,
   output logic direct_word_irq,
   // transfer unit
   input wire logic [7:0] ram_upper_address,
   output var dphp_pkg::dphp_ram_req_t tu_write,
   input wire logic tu_write_ack,
   output logic tu_read_req,
   input wire logic tu_read_ack,
   input wire logic [7:0] tu_read_data,
   output var dphp_pkg::dphp_ram_req_t tu_query,
   input wire logic tu_query_ack,
   input wire logic [7:0] tu_query_data,
   input wire logic chan_a_boundary,
   input wire logic chan_b_boundary
);
   import dphp_pkg::*;

   // ************************************************
   // host pin synchronisers
   // ************************************************
   logic [2:0] strobe_sync;
   logic [10:0] bus_sync;
   logic s_cs_n, s_we_n, s_oe_n;
   logic [2:0] s_addr;
   logic [7:0] s_data;

   dphp_sync #(.WIDTH(3), .IDLE(STROBE_IDLE)) u_strobe_sync (
      .clock(clock),
      .reset_n(reset_n),
      .pin_in({host_cs_n, host_we_n, host_oe_n}),
      .sync_out(strobe_sync)
   );

   dphp_sync #(.WIDTH(11), .IDLE(BUS_IDLE)) u_bus_sync (
      .clock(clock),
      .reset_n(reset_n),
      .pin_in({host_addr, host_data_bus_in}),
      .sync_out(bus_sync)
   );

   assign {s_cs_n, s_we_n, s_oe_n} = strobe_sync;
   assign {s_addr, s_data} = bus_sync;

   // ************************************************
   // host access events
   // ************************************************
   dphp_mode_t mode;
   logic hs, bound, direct;
   logic prev_we_n, prev_oe_n, prev_cs_n;
   logic [2:0] prev_addr;
   logic [7:0] latch_data;
   logic host_wr, host_rd;
   logic [2:0] acc_addr;

   assign mode = dphp_mode(handshake_enable, direct_word_select);
   assign hs = (mode == DPHP_HANDSHAKE);
   assign bound = (mode == DPHP_BOUND);
   assign direct = (mode == DPHP_DIRECT);

   // the access ends on the strobe rising edge; handshake ignores chip select
   assign host_wr = dual_port_enable && !prev_we_n && s_we_n && (hs || !prev_cs_n);
   assign host_rd = dual_port_enable && !prev_oe_n && s_oe_n && (hs || !prev_cs_n);
   // handshake mode reaches only the low bytes
   assign acc_addr = hs ? (host_wr ? ADDR_WR_LOW : ADDR_RD_LOW) : prev_addr;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         prev_we_n <= 1'b1;
         prev_oe_n <= 1'b1;
         prev_cs_n <= 1'b1;
         prev_addr <= 3'h0;
      end else begin
         prev_we_n <= s_we_n;
         prev_oe_n <= s_oe_n;
         prev_cs_n <= s_cs_n;
         prev_addr <= s_addr;
      end
   end

   // data stands while the strobe is low; keep the last value seen
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         latch_data <= DATA_RESET;
      end else if (!s_we_n) begin
         latch_data <= s_data;
      end
   end

   function automatic logic hit(input logic ev, input logic [2:0] a, input logic [2:0] r);
      return ev && (a == r);
   endfunction

   logic hw_data, hr_data, hw_low, hr_low, hw_query, hw_csr;
   logic cw_low, cr_wlow, cw_rlow, cr_rlow, cw_rhigh, cr_csr, cw_csr;

   assign hw_data = host_wr && (acc_addr == ADDR_WR_HIGH || acc_addr == ADDR_WR_LOW);
   assign hr_data = host_rd && (acc_addr == ADDR_RD_HIGH || acc_addr == ADDR_RD_LOW);
   assign hw_low = hit(host_wr, acc_addr, ADDR_WR_LOW);
   assign hr_low = hit(host_rd, acc_addr, ADDR_RD_LOW);
   assign hw_query = !hs && hit(host_wr, acc_addr, ADDR_QUERY);
   assign hw_csr = !hs && hit(host_wr, acc_addr, ADDR_CSR);
   assign cw_low = hit(cpu_req.sel && cpu_req.wr, cpu_req.addr, ADDR_WR_LOW);
   assign cr_wlow = hit(cpu_req.sel && cpu_req.rd, cpu_req.addr, ADDR_WR_LOW);
   assign cw_rlow = hit(cpu_req.sel && cpu_req.wr, cpu_req.addr, ADDR_RD_LOW);
   assign cr_rlow = hit(cpu_req.sel && cpu_req.rd, cpu_req.addr, ADDR_RD_LOW);
   assign cw_rhigh = hit(cpu_req.sel && cpu_req.wr, cpu_req.addr, ADDR_RD_HIGH);
   assign cr_csr = hit(cpu_req.sel && cpu_req.rd, cpu_req.addr, ADDR_CSR);
   assign cw_csr = hit(cpu_req.sel && cpu_req.wr, cpu_req.addr, ADDR_CSR);

   // ************************************************
   // data registers
   // ************************************************
   logic [7:0] host_write_data_high, host_write_data_low;
   logic [7:0] host_read_data_high, host_read_data_low;
   logic [7:0] query_buffer;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         host_write_data_high <= DATA_RESET;
         host_write_data_low <= DATA_RESET;
      end else if (hw_data) begin
         // handshake capture happens on the write-strobe rise
         if (acc_addr == ADDR_WR_LOW) begin
            host_write_data_low <= latch_data;
         end else begin
            host_write_data_high <= latch_data;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         host_read_data_high <= DATA_RESET;
         host_read_data_low <= DATA_RESET;
      end else if (bound && tu_read_ack) begin
         host_read_data_high <= tu_read_data;
         host_read_data_low <= tu_read_data;
      end else if (!bound) begin
         if (cw_rhigh && !hs) begin
            host_read_data_high <= cpu_req.wdata;
         end
         if (cw_rlow) begin
            host_read_data_low <= cpu_req.wdata;
         end
      end
   end

   // ************************************************
   // transfer unit requests
   // ************************************************
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         tu_write <= '0;
      end else if (bound && hw_data) begin
         tu_write.valid <= 1'b1;
         tu_write.data <= latch_data;
      end else if (tu_write_ack) begin
         tu_write.valid <= 1'b0;
      end
   end

   // in bound mode a fresh byte is asked for whenever the host consumes one
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         tu_read_req <= 1'b0;
      end else if (bound && hr_data) begin
         tu_read_req <= 1'b1;
      end else if (tu_read_ack) begin
         tu_read_req <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         tu_query <= '0;
      end else if (hw_query) begin
         tu_query.valid <= 1'b1;
         tu_query.addr <= {ram_upper_address, latch_data};
      end else if (tu_query_ack) begin
         tu_query.valid <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         query_buffer <= DATA_RESET;
      end else if (hw_query) begin
         query_buffer <= latch_data;
      end else if (tu_query_ack) begin
         query_buffer <= tu_query_data;
      end
   end

   // ************************************************
   // port_control_status
   // ************************************************
   logic query_holds_address_flag;
   logic wait_request_pin_enable;
   logic ready_on_host_write_enable, ready_on_host_read_enable;
   logic host_write_end_flag, host_read_end_flag;
   logic write_end_irq_enable, read_end_irq_enable;
   logic wr_end_seen, rd_end_seen;
   logic wr_end_set, rd_end_set, wr_end_clr, rd_end_clr;
   logic [7:0] port_control_status;

   assign port_control_status = {query_holds_address_flag, wait_request_pin_enable,
      ready_on_host_write_enable, ready_on_host_read_enable, host_write_end_flag,
      host_read_end_flag, write_end_irq_enable, read_end_irq_enable};

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         query_holds_address_flag <= CSR_RESET[BIT_QUERY];
      end else if (hw_query) begin
         query_holds_address_flag <= 1'b1;
      end else if (tu_query_ack) begin
         query_holds_address_flag <= 1'b0;
      end
   end

   // the host sets the pin enables except in handshake, where the cpu does
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wait_request_pin_enable <= CSR_RESET[BIT_WRQ_EN];
         ready_on_host_write_enable <= CSR_RESET[BIT_RDY_WR_EN];
         ready_on_host_read_enable <= CSR_RESET[BIT_RDY_RD_EN];
      end else if (hw_csr) begin
         wait_request_pin_enable <= latch_data[BIT_WRQ_EN];
         ready_on_host_write_enable <= latch_data[BIT_RDY_WR_EN];
         ready_on_host_read_enable <= latch_data[BIT_RDY_RD_EN];
      end else if (hs && cw_csr) begin
         wait_request_pin_enable <= cpu_req.wdata[BIT_WRQ_EN];
         ready_on_host_write_enable <= cpu_req.wdata[BIT_RDY_WR_EN];
         ready_on_host_read_enable <= cpu_req.wdata[BIT_RDY_RD_EN];
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         write_end_irq_enable <= CSR_RESET[BIT_WR_IRQ_EN];
         read_end_irq_enable <= CSR_RESET[BIT_RD_IRQ_EN];
      end else if (cw_csr) begin
         write_end_irq_enable <= cpu_req.wdata[BIT_WR_IRQ_EN];
         read_end_irq_enable <= cpu_req.wdata[BIT_RD_IRQ_EN];
      end
   end

   // a flag read as 1 arms the clear; any later csr write consumes the arm
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wr_end_seen <= 1'b0;
         rd_end_seen <= 1'b0;
      end else if (cr_csr) begin
         wr_end_seen <= host_write_end_flag;
         rd_end_seen <= host_read_end_flag;
      end else if (cw_csr) begin
         wr_end_seen <= 1'b0;
         rd_end_seen <= 1'b0;
      end
   end

   assign wr_end_set = (bound && chan_b_boundary) || (!bound && hw_low);
   assign rd_end_set = (bound && chan_a_boundary) || (!bound && hr_low);
   assign wr_end_clr = (cw_csr && wr_end_seen && !cpu_req.wdata[BIT_WR_END])
      || (!bound && (cr_wlow || cw_low));
   assign rd_end_clr = (cw_csr && rd_end_seen && !cpu_req.wdata[BIT_RD_END])
      || (!bound && (cr_rlow || cw_rlow));

   // a set in the clearing cycle wins
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         host_write_end_flag <= CSR_RESET[BIT_WR_END];
         host_read_end_flag <= CSR_RESET[BIT_RD_END];
      end else begin
         host_write_end_flag <= wr_end_set || (host_write_end_flag && !wr_end_clr);
         host_read_end_flag <= rd_end_set || (host_read_end_flag && !rd_end_clr);
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         write_end_irq <= 1'b0;
         read_end_irq <= 1'b0;
         direct_word_irq <= 1'b0;
      end else begin
         write_end_irq <= host_write_end_flag && write_end_irq_enable;
         read_end_irq <= host_read_end_flag && read_end_irq_enable;
         // only the low bytes raise the direct-word request
         direct_word_irq <= direct && (hw_low || hr_low);
      end
   end

   // ************************************************
   // internal cpu read port
   // ************************************************
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         cpu_rdata <= DATA_RESET;
      end else if (cpu_req.sel && cpu_req.rd) begin
         unique case (cpu_req.addr)
            ADDR_WR_HIGH: cpu_rdata <= host_write_data_high;
            ADDR_WR_LOW: cpu_rdata <= host_write_data_low;
            ADDR_QUERY: cpu_rdata <= query_buffer;
            ADDR_CSR: cpu_rdata <= port_control_status;
            default: cpu_rdata <= DATA_RESET;
         endcase
      end
   end

   // ************************************************
   // host data bus
   // ************************************************
   logic host_reading;
   logic [2:0] rd_addr;

   assign host_reading = dual_port_enable && !s_oe_n && (hs || !s_cs_n);
   assign rd_addr = hs ? ADDR_RD_LOW : s_addr;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         host_data_bus_out <= DATA_RESET;
         host_data_bus_oe_n <= 1'b1;
      end else begin
         host_data_bus_oe_n <= !host_reading;
         unique case (rd_addr)
            ADDR_RD_HIGH: host_data_bus_out <= host_read_data_high;
            ADDR_RD_LOW: host_data_bus_out <= host_read_data_low;
            ADDR_QUERY: host_data_bus_out <= query_buffer;
            ADDR_CSR: host_data_bus_out <= port_control_status;
            default: host_data_bus_out <= DATA_RESET;
         endcase
      end
   end

   // ************************************************
   // ready pin
   // ************************************************
   logic hold_wr, hold_rd, hs_ready_high, ready_release, ready_active;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         hold_wr <= 1'b0;
         hold_rd <= 1'b0;
      end else begin
         hold_wr <= hw_data || (hold_wr && !(bound ? wr_end_clr : cr_wlow));
         hold_rd <= hr_data || (hold_rd && !(bound ? rd_end_clr : cw_rlow));
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         hs_ready_high <= 1'b0;
      end else if (cr_wlow) begin
         hs_ready_high <= 1'b1;
      end else if (s_oe_n && !s_we_n) begin
         hs_ready_high <= 1'b0;
      end
   end

   assign ready_release = hs ? hs_ready_high
      : (ready_on_host_write_enable && hold_wr)
      || (ready_on_host_read_enable && hold_rd);
   assign ready_active = dual_port_enable && (hs || ready_on_host_write_enable
      || ready_on_host_read_enable);

   // open drain: only ever pulls low
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ready_out <= 1'b0;
         ready_oe_n <= 1'b1;
      end else begin
         ready_out <= 1'b0;
         ready_oe_n <= !(ready_active && !ready_release);
      end
   end

   // ************************************************
   // wait-request pin
   // ************************************************
   logic hs_wait_high, wait_done, wait_arm, wait_level;

   assign wait_arm = hs && !s_oe_n && !hs_wait_high;

   dphp_wait_timer u_wait_timer (
      .clock(clock),
      .reset_n(reset_n),
      .arm(wait_arm),
      .done(wait_done)
   );

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         hs_wait_high <= 1'b0;
      end else if (wait_done) begin
         hs_wait_high <= 1'b1;
      end else if (cw_rlow) begin
         hs_wait_high <= 1'b0;
      end
   end

   // bound mode holds the pin low while a transfer is still owed
   assign wait_level = hs ? hs_wait_high
      : !(tu_write.valid || tu_read_req || tu_query.valid);

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wait_request_n_out <= 1'b1;
         wait_request_n_oe_n <= 1'b1;
      end else if (dual_port_enable && wait_request_pin_enable) begin
         wait_request_n_out <= wait_level;
         wait_request_n_oe_n <= 1'b0;
      end else begin
         wait_request_n_out <= port_level;
         wait_request_n_oe_n <= port_oe_n;
      end
   end

endmodule

`default_nettype wire

/* bench/dphp_port_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module dphp_port_properties (
   // system
   input wire logic clock,
   input wire logic reset_n,
   // pins
   input wire logic handshake_enable,
   input wire logic host_oe_n,
   input wire logic host_data_bus_oe_n,
   input wire logic ready_out,
   input wire logic direct_word_irq,
   // transfer unit
   input wire dphp_pkg::dphp_ram_req_t tu_write,
   input wire logic tu_write_ack,
   input wire dphp_pkg::dphp_ram_req_t tu_query,
   input wire logic [7:0] ram_upper_address
);
   import dphp_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence s_read_end;
      handshake_enable && $rose(host_oe_n);
   endsequence
   a_ready_open: assert property (ready_out == 1'b0)
      else $error("ready pin driven high");
   a_bus_drive: assert property ($fell(host_data_bus_oe_n) |-> !$past(host_oe_n, 3))
      else $error("bus driven without output enable");
   a_bus_release: assert property (s_read_end |-> ##[1:4] host_data_bus_oe_n)
      else $error("bus held after output enable");
   a_irq_pulse: assert property (direct_word_irq |=> !direct_word_irq)
      else $error("irq longer than a cycle");
   a_irq_mode: assert property (direct_word_irq |-> !handshake_enable)
      else $error("irq in handshake mode");
   a_tu_hold: assert property (tu_write.valid && !tu_write_ack |=> tu_write.valid)
      else $error("ram byte dropped");
   a_tu_drop: assert property (tu_write.valid && tu_write_ack |=> !tu_write.valid)
      else $error("ram byte kept");
   a_query_addr: assert property ($rose(tu_query.valid) |->
      tu_query.addr[15:8] == ram_upper_address)
      else $error("query upper address wrong");
endmodule
bind dphp_port dphp_port_properties u_props (.clock, .reset_n, .handshake_enable, .host_oe_n,
   .host_data_bus_oe_n, .ready_out, .direct_word_irq, .tu_write, .tu_write_ack, .tu_query,
   .ram_upper_address);
`default_nettype wire

/* bench/dphp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dphp_host_model (
   // system
   input wire logic clock,
   // host pins
   output logic host_cs_n,
   output logic host_we_n,
   output logic host_oe_n,
   output logic [2:0] host_addr,
   output logic [7:0] host_data_bus_in,
   input wire logic [7:0] host_data_bus_out,
   input wire logic host_data_bus_oe_n
);
   logic drv = 1'b0;
   logic [7:0] dq = 8'h00;
   // a released bus shows the inverse of the last value
   assign host_data_bus_in = drv ? dq : (host_data_bus_oe_n ? ~dq : host_data_bus_out);
   initial begin
      host_cs_n = 1'b1;
      host_we_n = 1'b1;
      host_oe_n = 1'b1;
      host_addr = 3'h0;
   end
   task automatic hw(input logic [2:0] a, input logic [7:0] d);
      @(negedge clock);
      host_addr = a;
      dq = d;
      drv = 1'b1;
      host_cs_n = 1'b0;
      host_we_n = 1'b0;
      repeat (3) @(negedge clock);
      host_we_n = 1'b1;
      @(negedge clock);
      host_cs_n = 1'b1;
      drv = 1'b0;
      repeat (6) @(negedge clock);
   endtask
   task automatic hr(input logic [2:0] a, output logic [7:0] d);
      @(negedge clock);
      host_addr = a;
      host_cs_n = 1'b0;
      host_oe_n = 1'b0;
      repeat (5) @(negedge clock);
      d = host_data_bus_in;
      host_oe_n = 1'b1;
      @(negedge clock);
      host_cs_n = 1'b1;
      dq = d;
      repeat (6) @(negedge clock);
   endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import dphp_pkg::*;
   logic clock = 1'b0, reset_n = 1'b0, dual_port_enable = 1'b1, port_level = 1'b1;
   logic handshake_enable = 1'b0, direct_word_select = 1'b1, port_oe_n = 1'b1;
   logic host_cs_n, host_we_n, host_oe_n, host_data_bus_oe_n, ready_out, ready_oe_n;
   logic wait_request_n_out, wait_request_n_oe_n, write_end_irq, read_end_irq;
   logic direct_word_irq, tu_read_req, tu_write_ack = 1'b0, tu_read_ack = 1'b0;
   logic tu_query_ack = 1'b0, chan_a_boundary = 1'b0, chan_b_boundary = 1'b0;
   logic [2:0] host_addr;
   logic [7:0] host_data_bus_in, host_data_bus_out, cpu_rdata, tu_query_data, v, wd;
   logic [7:0] ram_upper_address = 8'h80, tu_read_data = 8'h9E;
   dphp_cpu_req_t cpu_req = '0;
   dphp_ram_req_t tu_write, tu_query;
   int failures = 0, check_count = 0, irqs = 0;
   // ram stand-in: each byte holds the inverse of its low address
   assign tu_query_data = ~tu_query.addr[7:0];
   dphp_port DUT (.clock, .reset_n, .dual_port_enable, .handshake_enable, .direct_word_select,
      .host_cs_n, .host_we_n, .host_oe_n, .host_addr, .host_data_bus_in, .host_data_bus_out,
      .host_data_bus_oe_n, .ready_out, .ready_oe_n, .wait_request_n_out, .wait_request_n_oe_n,
      .port_level, .port_oe_n, .cpu_req, .cpu_rdata, .write_end_irq, .read_end_irq,
      .direct_word_irq, .ram_upper_address, .tu_write, .tu_write_ack, .tu_read_req,
      .tu_read_ack, .tu_read_data, .tu_query, .tu_query_ack, .tu_query_data,
      .chan_a_boundary, .chan_b_boundary);
   dphp_host_model m (.clock, .host_cs_n, .host_we_n, .host_oe_n, .host_addr,
      .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe_n);
   initial forever #25 clock = ~clock;
   // transfer unit stand-in acks every request after one cycle
   always @(negedge clock) begin
      tu_write_ack <= tu_write.valid & ~tu_write_ack;
      tu_query_ack <= tu_query.valid & ~tu_query_ack;
      tu_read_ack <= tu_read_req & ~tu_read_ack;
      if (tu_write.valid && !tu_write_ack) wd <= tu_write.data;
      if (direct_word_irq === 1'b1) irqs <= irqs + 1;
   end
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cw(input logic [2:0] a, input logic [7:0] d);
      @(negedge clock);
      cpu_req = {1'b1, 1'b1, 1'b0, a, d};
      @(negedge clock);
      cpu_req = '0;
   endtask
   task automatic cc(input logic [2:0] a, input logic [7:0] e, input string n);
      @(negedge clock);
      cpu_req = {1'b1, 1'b0, 1'b1, a, 8'h00};
      @(negedge clock);
      cpu_req = '0;
      @(negedge clock);
      chk(n, cpu_rdata, e);
   endtask
   task automatic hc(input logic [2:0] a, input logic [7:0] e, input string n);
      m.hr(a, v);
      chk(n, v, e);
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #(4000 * 50);
      failures++;
      report_and_stop;
   end
   initial begin
      repeat (6) @(negedge clock);
      reset_n = 1'b1;
      repeat (3) @(negedge clock);
      cc(ADDR_CSR, CSR_RESET, "csr");
      chk("pins", {5'h00, ready_oe_n, wait_request_n_out, wait_request_n_oe_n}, 8'h07);
      m.hw(ADDR_WR_HIGH, 8'h5A);
      m.hw(ADDR_WR_LOW, 8'hA5);
      cc(ADDR_CSR, 8'h08, "csr");
      chk("irq", irqs[7:0], 8'h01);
      cc(ADDR_WR_HIGH, 8'h5A, "wr_high");
      cc(ADDR_WR_LOW, 8'hA5, "wr_low");
      cw(ADDR_RD_HIGH, 8'h12);
      cw(ADDR_RD_LOW, 8'h34);
      hc(ADDR_RD_HIGH, 8'h12, "rd_high");
      hc(ADDR_RD_LOW, 8'h34, "rd_low");
      chk("irq", irqs[7:0], 8'h02);
      cc(ADDR_CSR, 8'h04, "csr");
      $display("end direct word test");
      handshake_enable = 1'b1;
      m.hw(ADDR_WR_HIGH, 8'h3C);
      chk("hs_ready", {7'h00, ready_oe_n}, 8'h00);
      cc(ADDR_WR_LOW, 8'h3C, "hs_wr_low");
      chk("hs_ready", {7'h00, ready_oe_n}, 8'h01);
      cw(ADDR_RD_LOW, 8'h77);
      hc(ADDR_RD_HIGH, 8'h77, "hs_rd_low");
      cc(ADDR_CSR, 8'h04, "hs_csr");
      cw(ADDR_RD_LOW, 8'h00);
      $display("end handshake test");
      handshake_enable = 1'b0;
      direct_word_select = 1'b0;
      m.hw(ADDR_WR_HIGH, 8'h61);
      chk("ram_byte", wd, 8'h61);
      m.hw(ADDR_WR_LOW, 8'h62);
      chk("ram_byte", wd, 8'h62);
      m.hr(ADDR_RD_LOW, v);
      hc(ADDR_RD_HIGH, 8'h9E, "rd_high");
      hc(ADDR_RD_LOW, 8'h9E, "rd_low");
      m.hw(ADDR_QUERY, 8'h21);
      hc(ADDR_QUERY, 8'hDE, "query");
      cc(ADDR_CSR, 8'h00, "csr");
      chan_a_boundary = 1'b1;
      chan_b_boundary = 1'b1;
      @(negedge clock);
      chan_a_boundary = 1'b0;
      chan_b_boundary = 1'b0;
      cw(ADDR_CSR, 8'h02);
      cc(ADDR_CSR, 8'h0E, "csr");
      chk("irqs", {6'h00, write_end_irq, read_end_irq}, 8'h02);
      cw(ADDR_CSR, 8'h02);
      cc(ADDR_CSR, 8'h02, "csr");
      m.hw(ADDR_CSR, 8'h60);
      chk("pins", {5'h00, ready_oe_n, wait_request_n_out, wait_request_n_oe_n}, 8'h02);
      m.hw(ADDR_WR_LOW, 8'h63);
      chk("pins", {5'h00, ready_oe_n, wait_request_n_out, wait_request_n_oe_n}, 8'h06);
      $display("end bound buffer test");
      report_and_stop;
   end
endmodule
`default_nettype wire
